// ===== logic/vliw_params.svh
/*
 constants of the five-slot core: sizes, reset values, field positions, timing.
 assumes inclusion by bare name from the design files.
*/
`ifndef VLIW_PARAMS_SVH
`define VLIW_PARAMS_SVH

// =====================================================
// sizes
`define NUM_REGS 128
`define SLOTS 5
`define LS_PORTS 2
`define WB_LIMIT 3'd5

// =====================================================
// constant registers
`define REG_ZERO 32'h0000_0000
`define REG_ONE 32'h0000_0001

// =====================================================
// program counter
`define PC_RESET 32'h0000_0000
`define PC_STEP 32'h0000_0010
`define EXC_VECTOR 32'h0000_0100

// =====================================================
// control_status_word fields
`define CSW_RESET 32'h0000_0000
`define CSW_WBE_BIT 0
`define CSW_TRP_BIT 1
`define CSW_CS_BIT 2

// =====================================================
// timing, in issue cycles
`define LOAD_LAT 3
`define BR_DELAY 3

`endif

// ===== logic/vliw_pkg.sv
/*
 types of the five-slot core: operation codes, special register select, branch states.
 assumes nothing of its surroundings.
*/
`default_nettype none
package vliw_pkg;
   // operation codes of one slot
   typedef enum logic [2:0] {
      OP_NOP = 3'h0,
      OP_IADD = 3'h1,
      OP_LOAD = 3'h2,
      OP_JMPF = 3'h3,
      OP_RDSPEC = 3'h4,
      OP_WRSPEC = 3'h5
   } op_t;

   // special register select, taken from the immediate
   typedef enum logic [2:0] {
      SPEC_CSW = 3'h0,
      SPEC_IBT = 3'h1,
      SPEC_CBT = 3'h2,
      SPEC_TALLY_LO = 3'h3,
      SPEC_TALLY_HI = 3'h4,
      SPEC_PC = 3'h5
   } spec_t;

   // branch delay tracking, gray along the path
   typedef enum logic [1:0] {
      BR_IDLE = 2'b00,
      BR_D1 = 2'b01,
      BR_D2 = 2'b11,
      BR_D3 = 2'b10
   } br_state_t;
endpackage
`default_nettype wire

// ===== logic/regfile_5w.sv
/*
 regfile_5w: 128 x 32 register file, fifteen read ports, five write ports.
 assumes writers never name entries 0 or 1; such writes are dropped.
*/
`timescale 1ns/100ps
`default_nettype none
`include "vliw_params.svh"

module regfile_5w (
   input wire logic i_clk,
   input wire logic [14:0][6:0] i_rd_idx,
   output logic [14:0][31:0] o_rd_data,
   input wire logic [4:0] i_we,
   input wire logic [4:0][6:0] i_wr_idx,
   input wire logic [4:0][31:0] i_wr_data
);
   // storage for entries 2..127 only
   logic [31:0] mem [2:`NUM_REGS-1];

   // =====================================================
   // read ports, entries 0 and 1 are constants
   always_comb begin
      for (int p = 0; p < 15; p++) begin
         if (i_rd_idx[p] == 7'h0) begin
            o_rd_data[p] = `REG_ZERO;
         end else if (i_rd_idx[p] == 7'h1) begin
            o_rd_data[p] = `REG_ONE;
         end else begin
            o_rd_data[p] = mem[i_rd_idx[p]];
         end
      end
   end

   // =====================================================
   // write ports, higher port wins on the same entry
   always_ff @(posedge i_clk) begin
      for (int w = 0; w < `SLOTS; w++) begin
         if (i_we[w] && i_wr_idx[w] > 7'h1) begin
            mem[i_wr_idx[w]] <= i_wr_data[w];
         end
      end
   end
endmodule
`default_nettype wire

// ===== logic/load_port.sv
/*
 load_port: one word load unit; address out one cycle after issue,
 data written back two cycles after issue, usable three cycles after issue.
 assumes memory returns i_mem_rdata one cycle after o_mem_rd, on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

module load_port (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_issue,
   input wire logic [31:0] i_addr,
   input wire logic [6:0] i_dst,
   input wire logic [31:0] i_mem_rdata,
   output logic o_mem_rd,
   output logic [31:0] o_mem_addr,
   output logic o_wb_valid,
   output logic [6:0] o_wb_dst,
   output logic [31:0] o_wb_data
);
   logic v1, v2, next_v1, next_v2;
   logic [6:0] dst1, dst2, next_dst1, next_dst2;
   logic [31:0] addr1, next_addr1;

   // =====================================================
   // two pipeline stages
   always_comb begin
      next_v1 = i_issue;
      next_dst1 = i_issue ? i_dst : dst1;
      next_addr1 = i_issue ? i_addr : addr1;
      next_v2 = v1;
      next_dst2 = dst1;
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         v1 <= 1'b0;
         v2 <= 1'b0;
         dst1 <= 7'h0;
         dst2 <= 7'h0;
         addr1 <= 32'h0;
      end else begin
         v1 <= next_v1;
         v2 <= next_v2;
         dst1 <= next_dst1;
         dst2 <= next_dst2;
         addr1 <= next_addr1;
      end
   end

   // outputs
   assign o_mem_rd = v1;
   assign o_mem_addr = addr1;
   assign o_wb_valid = v2;
   assign o_wb_dst = dst2;
   assign o_wb_data = i_mem_rdata;
endmodule
`default_nettype wire

// ===== logic/vliw_core.sv
/*
 vliw_core: issue, guarding, latency and register model of a five-slot core.
 assumes one instruction presented per cycle at o_pc, memory answering
 a read one cycle after o_mem_rd, and all inputs on i_clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "vliw_params.svh"

// =====================================================

module vliw_core (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_stall,
   input wire logic i_exception,
   input wire vliw_pkg::op_t [4:0] i_op,
   input wire logic [4:0][6:0] i_guard,
   input wire logic [4:0][6:0] i_src1,
   input wire logic [4:0][6:0] i_src2,
   input wire logic [4:0][6:0] i_dst,
   input wire logic [4:0][31:0] i_imm,
   input wire logic [1:0][31:0] i_mem_rdata,
   output logic [31:0] o_pc,
   output logic [1:0] o_mem_rd,
   output logic [1:0][31:0] o_mem_addr,
   output logic o_exception
);
   import vliw_pkg::*;

   // read ports and write-back paths
   logic [14:0][6:0] rd_idx;
   logic [14:0][31:0] rd_data;
   logic [4:0] g_true;
   logic [4:0] alu_we;
   logic [4:0][31:0] alu_res;
   logic [1:0] ld_issue;
   logic [1:0][31:0] ld_addr;
   logic [1:0] ld_wb_v;
   logic [1:0][6:0] ld_wb_dst;
   logic [1:0][31:0] ld_wb_data;
   logic [4:0] wb_we;
   logic [4:0][6:0] wb_idx;
   logic [4:0][31:0] wb_data;
   logic [2:0] wb_count;
   logic overflow;

   // control flow and special register writes
   logic br_take;
   logic br_by0;
   logic br_land;
   logic [31:0] br_new;
   logic sw_we;
   spec_t sw_sel;
   logic [31:0] sw_val;

   // state
   logic [31:0] pc, next_pc;
   logic [31:0] csw, next_csw;
   logic [31:0] ibt, next_ibt;
   logic [31:0] cbt, next_cbt;
   logic [63:0] tally, next_tally;
   br_state_t br_state, next_br_state;
   logic [31:0] br_target, next_br_target;
   logic exc, next_exc;

   // =====================================================
   // register file
   // three read ports per slot: guard, source 1, source 2
   always_comb begin
      for (int s = 0; s < `SLOTS; s++) begin
         rd_idx[3*s] = i_guard[s];
         rd_idx[3*s+1] = i_src1[s];
         rd_idx[3*s+2] = i_src2[s];
      end
   end

   regfile_5w u_regs (
      .i_clk(i_clk),
      .i_rd_idx(rd_idx),
      .o_rd_data(rd_data),
      .i_we(wb_we),
      .i_wr_idx(wb_idx),
      .i_wr_data(wb_data)
   );

   // =====================================================
   // load units on slots 0 and 1
   generate
      for (genvar p = 0; p < `LS_PORTS; p++) begin : g_ld
         load_port u_ld (
            .i_clk(i_clk),
            .i_reset(i_reset),
            .i_issue(ld_issue[p]),
            .i_addr(ld_addr[p]),
            .i_dst(i_dst[p]),
            .i_mem_rdata(i_mem_rdata[p]),
            .o_mem_rd(o_mem_rd[p]),
            .o_mem_addr(o_mem_addr[p]),
            .o_wb_valid(ld_wb_v[p]),
            .o_wb_dst(ld_wb_dst[p]),
            .o_wb_data(ld_wb_data[p])
         );
      end
   endgenerate

   // =====================================================
   // special register read value
   function automatic logic [31:0] spec_value(input spec_t sel);
      logic [31:0] v;
      v = 32'h0;
      case (sel)
         SPEC_CSW: v = csw;
         SPEC_IBT: v = ibt;
         SPEC_CBT: v = cbt;
         SPEC_TALLY_LO: v = tally[31:0];
         SPEC_TALLY_HI: v = tally[63:32];
         SPEC_PC: v = pc;
         default: v = 32'h0;
      endcase
      return v;
   endfunction

   // =====================================================
   // decode and execute the five slots of one instruction
   always_comb begin
      alu_we = '0;
      alu_res = '0;
      ld_issue = '0;
      ld_addr = '0;
      br_take = 1'b0;
      br_by0 = 1'b0;
      br_new = 32'h0;
      sw_we = 1'b0;
      sw_sel = SPEC_CSW;
      sw_val = 32'h0;
      for (int s = 0; s < `SLOTS; s++) begin
         g_true[s] = rd_data[3*s][0];
         if (!i_stall && g_true[s]) begin
            case (i_op[s])
               OP_IADD: begin
                  alu_we[s] = 1'b1;
                  alu_res[s] = rd_data[3*s+1] + rd_data[3*s+2];
               end
               OP_RDSPEC: begin
                  alu_we[s] = 1'b1;
                  alu_res[s] = spec_value(spec_t'(i_imm[s][2:0]));
               end
               OP_LOAD: begin
                  // only slots 0 and 1 pass this check, so bit zero of s picks the unit
                  if (s < `LS_PORTS) begin
                     ld_issue[s[0]] = 1'b1;
                     ld_addr[s[0]] = rd_data[3*s+1] + i_imm[s];
                  end
               end
               OP_JMPF: begin
                  if (!rd_data[3*s+1][0] && !br_take && br_state == BR_IDLE) begin
                     br_take = 1'b1;
                     br_new = rd_data[3*s+2];
                     // flags a jump armed by slot 0, for the guard check
                     if (s == 0) begin
                        br_by0 = 1'b1;
                     end
                  end
               end
               OP_WRSPEC: begin
                  sw_we = 1'b1;
                  sw_sel = spec_t'(i_imm[s][2:0]);
                  sw_val = rd_data[3*s+1];
               end
               default: begin
               end
            endcase
         end
      end
   end

   // =====================================================
   // write-back merge; a completing load takes its slot's port
   always_comb begin
      wb_count = 3'h0;
      for (int s = 0; s < `SLOTS; s++) begin
         wb_we[s] = alu_we[s];
         wb_idx[s] = i_dst[s];
         wb_data[s] = alu_res[s];
         wb_count = wb_count + 3'(alu_we[s]);
      end
      for (int p = 0; p < `LS_PORTS; p++) begin
         if (ld_wb_v[p]) begin
            wb_we[p] = 1'b1;
            wb_idx[p] = ld_wb_dst[p];
            wb_data[p] = ld_wb_data[p];
            wb_count = wb_count + 3'h1;
         end
      end
      overflow = wb_count > `WB_LIMIT;
   end

   // =====================================================
   // program counter, branch delay, special registers, tally
   always_comb begin
      next_pc = pc;
      next_br_state = br_state;
      next_br_target = br_target;
      next_ibt = ibt;
      next_cbt = cbt;
      next_csw = csw;
      next_tally = tally;
      br_land = 1'b0;
      if (!i_stall || csw[`CSW_CS_BIT]) begin
         next_tally = tally + 64'h1;
      end
      if (!i_stall) begin
         next_pc = pc + `PC_STEP;
         unique case (br_state)
            BR_IDLE: begin
               if (br_take) begin
                  next_br_state = BR_D1;
                  next_br_target = br_new;
               end
            end
            BR_D1: next_br_state = BR_D2;
            BR_D2: next_br_state = BR_D3;
            BR_D3: begin
               br_land = 1'b1;
               next_br_state = BR_IDLE;
               next_ibt = br_target;
               if (i_exception) begin
                  next_pc = `EXC_VECTOR;
               end else begin
                  next_pc = br_target;
                  next_cbt = br_target;
               end
            end
         endcase
      end
      // software writes beat the jump-time captures
      if (sw_we) begin
         case (sw_sel)
            SPEC_CSW: next_csw = sw_val;
            SPEC_IBT: next_ibt = sw_val;
            SPEC_CBT: next_cbt = sw_val;
            default: begin
            end
         endcase
      end
      // hardware set of the flag beats a software clear
      if (overflow) begin
         next_csw[`CSW_WBE_BIT] = 1'b1;
      end
      next_exc = next_csw[`CSW_WBE_BIT] & next_csw[`CSW_TRP_BIT];
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         pc <= `PC_RESET;
         br_state <= BR_IDLE;
         br_target <= 32'h0;
         ibt <= 32'h0;
         cbt <= 32'h0;
         csw <= `CSW_RESET;
         tally <= 64'h0;
         exc <= 1'b0;
      end else begin
         pc <= next_pc;
         br_state <= next_br_state;
         br_target <= next_br_target;
         ibt <= next_ibt;
         cbt <= next_cbt;
         csw <= next_csw;
         tally <= next_tally;
         exc <= next_exc;
      end
   end

   // outputs
   assign o_pc = pc;
   assign o_exception = exc;

   // =====================================================
   // assertions
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   zero_reg_a: assert property (i_guard[0] == 7'h0 |-> rd_data[0] == `REG_ZERO)
      else $error("entry zero did not read zero");
   one_reg_a: assert property (i_src1[1] == 7'h1 |-> rd_data[4] == `REG_ONE)
      else $error("entry one did not read one");
   tally_count_a: assert property (!i_stall |=> tally == $past(tally) + 64'h1)
      else $error("tally missed an unstalled cycle");
   guard_off_a: assert property (!g_true[0] |-> !alu_we[0] && !ld_issue[0] && !br_by0)
      else $error("false guard still acted");
   load_lat_a: assert property (ld_issue[0] |-> ##2 (ld_wb_v[0] && ld_wb_dst[0] == $past(i_dst[0], 2)))
      else $error("load write-back not two cycles after issue");
   branch_arm_a: assert property (br_take |=> br_state == BR_D1 && br_target == $past(br_new))
      else $error("taken jmpf not armed");
   delay_slots_a: assert property (br_take ##1 (!i_stall && !i_exception)[*3] |=> o_pc == $past(br_target))
      else $error("target not reached after three delay slots");
   spc_catch_a: assert property (br_land && !i_exception && !sw_we |=> cbt == $past(br_target))
      else $error("completed jump target not caught");
   dpc_catch_a: assert property (br_land && i_exception && !sw_we |=> ibt == $past(br_target) && o_pc == `EXC_VECTOR && cbt == $past(cbt))
      else $error("interrupted jump handled wrongly");
   wbe_flag_a: assert property (overflow |=> csw[`CSW_WBE_BIT])
      else $error("write-back overflow not flagged");

   dual_load_c: cover property (ld_issue[0] && ld_issue[1]);
   jump_done_c: cover property (br_land && !i_exception);
   jump_intr_c: cover property (br_land && i_exception);
   overflow_c: cover property (overflow);
endmodule
`default_nettype wire

// ===== tb/test_vliw_core.sv
/*
 test_vliw_core: self-checking bench for the five-slot core.
 assumes the core reads registers through load addresses (base plus zero
 displacement shows a register on o_mem_addr) and the fixed latencies of the core.
*/
`timescale 1ns/100ps
`default_nettype none
`include "vliw_params.svh"

module test_vliw_core;
   import vliw_pkg::*;

   // =====================================================
   // stimulus and observation
   logic i_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_stall = 1'b0;
   logic i_exception = 1'b0;
   op_t [4:0] i_op;
   logic [4:0][6:0] i_guard;
   logic [4:0][6:0] i_src1;
   logic [4:0][6:0] i_src2;
   logic [4:0][6:0] i_dst;
   logic [4:0][31:0] i_imm;
   logic [1:0][31:0] i_mem_rdata = '0;
   logic [31:0] o_pc;
   logic [1:0] o_mem_rd;
   logic [1:0][31:0] o_mem_addr;
   logic o_exception;
   int mismatches = 0;
   int num_checks = 0;
   logic [31:0] pc0;
   logic [31:0] ta;
   logic [31:0] tb;

   vliw_core vliw_core_inst (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_stall(i_stall),
      .i_exception(i_exception),
      .i_op(i_op),
      .i_guard(i_guard),
      .i_src1(i_src1),
      .i_src2(i_src2),
      .i_dst(i_dst),
      .i_imm(i_imm),
      .i_mem_rdata(i_mem_rdata),
      .o_pc(o_pc),
      .o_mem_rd(o_mem_rd),
      .o_mem_addr(o_mem_addr),
      .o_exception(o_exception)
   );

   // 50 ns clock
   always #25 i_clk = ~i_clk;

   // =====================================================
   // helpers
   task automatic final_report();
      if (mismatches == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // every slot back to an unguarded nop
   task automatic clr();
      for (int p = 0; p < 5; p++) begin
         i_op[p] = OP_NOP;
         i_guard[p] = 7'h01;
         i_src1[p] = 7'h00;
         i_src2[p] = 7'h00;
         i_dst[p] = 7'h7f;
         i_imm[p] = 32'h0;
      end
   endtask

   task automatic slot(input int p, input op_t op, input logic [6:0] g, input logic [6:0] s1,
                       input logic [6:0] s2, input logic [6:0] d, input logic [31:0] imm);
      i_op[p] = op;
      i_guard[p] = g;
      i_src1[p] = s1;
      i_src2[p] = s2;
      i_dst[p] = d;
      i_imm[p] = imm;
   endtask

   // hand the presented instruction to one edge, back at the falling edge
   task automatic go();
      @(posedge i_clk);
      @(negedge i_clk);
      clr();
   endtask

   // a register shows up as the address of a slot-one load
   task automatic peek(input logic [6:0] r, output logic [31:0] v);
      slot(1, OP_LOAD, 7'h01, r, 7'h00, 7'h7e, 32'h0);
      go();
      check({31'h0, o_mem_rd[1]}, 32'h1, "load strobe");
      v = o_mem_addr[1];
   endtask

   task automatic rd(input logic [6:0] r, input logic [31:0] exp);
      logic [31:0] v;
      peek(r, v);
      check(v, exp, "register value");
   endtask

   // a register is filled by a load whose data is v
   task automatic wr(input logic [6:0] r, input logic [31:0] v);
      i_mem_rdata[0] = v;
      slot(0, OP_LOAD, 7'h01, 7'h00, 7'h00, r, 32'h0);
      go();
      go();
      go();
   endtask

   task automatic spec(input logic [2:0] sel, input logic [6:0] d);
      slot(0, OP_RDSPEC, 7'h01, 7'h00, 7'h00, d, {29'h0, sel});
      go();
   endtask

   // =====================================================
   // watchdog
   initial begin
      repeat (20000) @(posedge i_clk);
      mismatches++;
      final_report();
   end

   // =====================================================
   // main sequence
   initial begin
      clr();
      repeat (16) @(negedge i_clk);
      i_reset = 1'b0;
      check(o_pc, `PC_RESET, "pc after reset");
      check({31'h0, o_exception}, 32'h0, "exception after reset");
      rd(7'h00, `REG_ZERO);
      rd(7'h01, `REG_ONE);
      wr(7'h7f, 32'hdead_beef);
      rd(7'h7f, 32'hdead_beef);
      // load latency and address
      wr(7'h06, 32'h0000_1000);
      i_mem_rdata[0] = 32'h0000_2000;
      slot(0, OP_LOAD, 7'h01, 7'h06, 7'h00, 7'h06, 32'h0000_0020);
      go();
      check({31'h0, o_mem_rd[0]}, 32'h1, "load strobe slot0");
      check(o_mem_addr[0], 32'h0000_1020, "load address");
      go();
      rd(7'h06, 32'h0000_1000);
      rd(7'h06, 32'h0000_2000);
      // add latency and guards
      wr(7'h05, 32'h0000_0040);
      wr(7'h08, 32'h0000_0007);
      slot(0, OP_IADD, 7'h01, 7'h05, 7'h01, 7'h08, 32'h0);
      rd(7'h08, 32'h0000_0007);
      rd(7'h08, 32'h0000_0041);
      slot(0, OP_IADD, 7'h00, 7'h05, 7'h05, 7'h08, 32'h0);
      go();
      rd(7'h08, 32'h0000_0041);
      wr(7'h07, 32'h0000_0002);
      slot(0, OP_IADD, 7'h07, 7'h05, 7'h05, 7'h08, 32'h0);
      go();
      rd(7'h08, 32'h0000_0041);
      wr(7'h07, 32'h0000_0003);
      slot(0, OP_IADD, 7'h07, 7'h05, 7'h05, 7'h08, 32'h0);
      go();
      rd(7'h08, 32'h0000_0080);
      slot(0, OP_LOAD, 7'h00, 7'h05, 7'h00, 7'h08, 32'h0);
      go();
      check({31'h0, o_mem_rd[0]}, 32'h0, "guarded-off load");
      // issue rate and stall
      pc0 = o_pc;
      go();
      check(o_pc, pc0 + `PC_STEP, "pc step");
      i_stall = 1'b1;
      go();
      i_stall = 1'b0;
      check(o_pc, pc0 + `PC_STEP, "pc held in stall");
      // taken jump with delay slots
      wr(7'h09, 32'h0000_0400);
      pc0 = o_pc;
      slot(0, OP_JMPF, 7'h01, 7'h00, 7'h09, 7'h7f, 32'h0);
      for (int k = 1; k < 4; k++) begin
         go();
         check(o_pc, pc0 + k * `PC_STEP, "delay slot pc");
      end
      go();
      check(o_pc, 32'h0000_0400, "jump target");
      // jump with true condition is not taken
      pc0 = o_pc;
      slot(0, OP_JMPF, 7'h01, 7'h01, 7'h09, 7'h7f, 32'h0);
      repeat (4) go();
      check(o_pc, pc0 + 4 * `PC_STEP, "untaken jump");
      spec(3'h2, 7'h0a);
      rd(7'h0a, 32'h0000_0400);
      // interrupted jump
      wr(7'h09, 32'h0000_0800);
      slot(0, OP_JMPF, 7'h01, 7'h00, 7'h09, 7'h7f, 32'h0);
      repeat (3) go();
      i_exception = 1'b1;
      go();
      i_exception = 1'b0;
      check(o_pc, `EXC_VECTOR, "exception vector");
      spec(3'h1, 7'h0a);
      rd(7'h0a, 32'h0000_0800);
      spec(3'h2, 7'h0a);
      rd(7'h0a, 32'h0000_0400);
      // cycle tally skips stalls while count-stalls is clear
      spec(3'h3, 7'h0b);
      i_stall = 1'b1;
      repeat (3) go();
      i_stall = 1'b0;
      spec(3'h3, 7'h0c);
      peek(7'h0b, ta);
      peek(7'h0c, tb);
      check(tb - ta, 32'h0000_0001, "tally step");
      // five write-backs are fine, six set the overflow flag
      // two idle cycles let the peek loads retire before the full instruction
      repeat (2) go();
      for (int p = 0; p < 5; p++) slot(p, OP_IADD, 7'h01, 7'h01, 7'h01, 7'(20 + p), 32'h0);
      go();
      spec(3'h0, 7'h0d);
      rd(7'h0d, `CSW_RESET);
      slot(0, OP_LOAD, 7'h01, 7'h00, 7'h00, 7'h19, 32'h0);
      go();
      go();
      for (int p = 0; p < 5; p++) slot(p, OP_IADD, 7'h01, 7'h01, 7'h01, 7'(20 + p), 32'h0);
      go();
      spec(3'h0, 7'h0d);
      rd(7'h0d, 32'h1 << `CSW_WBE_BIT);
      check({31'h0, o_exception}, 32'h0, "no trap while disabled");
      // software write of the completed latch, live pc and tally high reads
      slot(0, OP_WRSPEC, 7'h01, 7'h09, 7'h00, 7'h7f, 32'h0000_0002);
      go();
      spec(3'h2, 7'h0a);
      rd(7'h0a, 32'h0000_0800);
      pc0 = o_pc;
      spec(3'h5, 7'h10);
      rd(7'h10, pc0);
      spec(3'h4, 7'h0f);
      rd(7'h0f, 32'h0000_0000);
      // flag, trap enable and count-stalls all set by software
      wr(7'h0e, 32'h0000_0007);
      slot(0, OP_WRSPEC, 7'h01, 7'h0e, 7'h00, 7'h7f, 32'h0000_0000);
      go();
      check({31'h0, o_exception}, 32'h1, "trap on overflow flag");
      // with count-stalls set the tally also advances on stalled cycles
      spec(3'h3, 7'h0b);
      i_stall = 1'b1;
      repeat (3) go();
      i_stall = 1'b0;
      spec(3'h3, 7'h0c);
      peek(7'h0b, ta);
      peek(7'h0c, tb);
      check(tb - ta, 32'h0000_0004, "tally counts stalls");
      final_report();
   end
endmodule

`default_nettype wire
